// File: rtl/channel_attenuator.sv
// One channel's stepped attenuator and silence detector
`timescale 1ns/1ps
`default_nettype none
`include "stereo_dac_consts.svh"
module channel_attenuator (
   input  wire logic       clk_sys,
   input  wire logic       reset,
   input  wire logic       clkEn,
   input  wire logic       sampleTick,
   input  wire logic       sampleZero,
   input  wire logic [7:0] programmedLevel,
   input  wire logic       softMute,
   output logic      [7:0] appliedLevel,
   output logic            silent
);
   logic [2:0] rampCnt_reg;
   logic [9:0] zeroCnt_reg;
   logic [7:0] level_reg;
   logic       silent_reg;

   // Mute target is the floor of the silent band
   wire  [7:0] target     = softMute ? `ATTEN_MUTE_FLOOR : programmedLevel;
   // Codes 0..128 are all silence, so ramp straight through that band
   wire  [7:0] effLevel   = (level_reg <= `ATTEN_MUTE_MAX) ? `ATTEN_MUTE_MAX : level_reg;
   wire  [7:0] effTarget  = (target <= `ATTEN_MUTE_MAX) ? `ATTEN_MUTE_MAX : target;
   wire        stepNow    = sampleTick && (rampCnt_reg == `RAMP_SAMPLES);
   wire  [7:0] level_next = (effLevel == effTarget) ? target :
                            (effLevel < effTarget) ? 8'(effLevel + 8'h01) :
                            (effLevel == 8'h81)    ? target : 8'(effLevel - 8'h01);

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         rampCnt_reg <= 3'h0;
         level_reg   <= `ATTEN_RESET; // see R3
         zeroCnt_reg <= 10'h000;
         silent_reg  <= 1'b0;
      end else if (clkEn && sampleTick) begin
         rampCnt_reg <= 3'(rampCnt_reg + 3'h1);
         if (stepNow)
            level_reg <= level_next; // see R6 see R7 see R8
         if (!sampleZero) begin
            zeroCnt_reg <= 10'h000;
            silent_reg  <= 1'b0;
         end else if (zeroCnt_reg == `SILENCE_SAMPLES)
            silent_reg  <= 1'b1; // see R21
         else
            zeroCnt_reg <= 10'(zeroCnt_reg + 10'h001);
      end
   end

   assign appliedLevel = level_reg;
   assign silent       = silent_reg;

   a_step_once: assert property (@(posedge clk_sys) disable iff (reset) // see R6
      (level_reg != $past(level_reg)) |-> $past(stepNow && clkEn))
      else $error("attenuator moved off an eight-sample boundary");
   a_mute_dir: assert property (@(posedge clk_sys) disable iff (reset) // see R7
      (clkEn && stepNow && softMute && level_reg > 8'h81) |=> (level_reg == $past(level_reg) - 8'h01))
      else $error("soft mute did not step down by one");
   a_silent_clr: assert property (@(posedge clk_sys) disable iff (reset) // see R21
      (clkEn && sampleTick && !sampleZero) |=> !silent_reg)
      else $error("silence flag survived nonzero sample");
endmodule // channel_attenuator
`default_nettype wire

// File: rtl/stereo_dac_consts.svh
// Register offsets, field positions, reset values and timing counts of the DAC mode control bank
`ifndef STEREO_DAC_CONSTS_SVH
`define STEREO_DAC_CONSTS_SVH

`define IDX_LEFT_ATTEN      7'h10
`define IDX_RIGHT_ATTEN     7'h11
`define IDX_MUTE_OVER       7'h12
`define IDX_CHAN_DEEMPH     7'h13
`define IDX_FORMAT_FILTER   7'h14
`define IDX_TEST_RESERVED   7'h15
`define IDX_OUTPUT_FLAG     7'h16

`define WORD_BITS           16
`define WORD_ZERO_BIT       15
`define WORD_IDX_HI         14
`define WORD_IDX_LO         8

`define ATTEN_RESET         8'hFF
`define ATTEN_MUTE_MAX      8'h80
`define ATTEN_MUTE_FLOOR    8'h00
`define FORMAT_RESET        3'h5

`define POS_MUTE_LEFT       0
`define POS_MUTE_RIGHT      1
`define POS_OVERSAMPLE      6
`define POS_DIS_LEFT        0
`define POS_DIS_RIGHT       1
`define POS_DEEMPH_EN       4
`define POS_DEEMPH_RATE_LO  5
`define POS_FORMAT_LO       0
`define POS_ROLLOFF         5
`define POS_INVERT          0
`define POS_FLAG_POLARITY   1
`define POS_COMMON_FLAG     2

`define RAMP_SAMPLES        3'h7
`define SILENCE_SAMPLES     10'h3FF

`endif

// File: rtl/stereo_dac_mode_control.sv
// Serial-programmed mode control bank of a stereo audio DAC
`timescale 1ns/1ps
`default_nettype none
`include "stereo_dac_consts.svh"

// What this block does
// R1 - Word bit 15 zero, index in bits 14..8, data in 7..0; indices 10h..16h.
// R2 - Host writes zero to reserved test bits, all of index 15h.
// R3 - Left and right attenuation at 10h and 11h, reset to all ones.
// R4 - Codes 129..255 give half a decibel per code below 255.
// R5 - Codes 0..128 silence the channel completely.
// R6 - A new level is approached by one step every eight samples.
// R7 - Soft mute ramps the channel down to silence one step per eight samples.
// R8 - Releasing soft mute ramps back up to the programmed level.
// R9 - Oversampling bit: 64x clear, 128x set at 256..768 fs clocks.
// R10 - Oversampling bit: 32x clear, 64x set at 128 or 192 fs clocks.
// R11 - Host sets the oversampling bit at 192 kHz sample rates.
// R12 - Channel disable bit holds that output at bipolar zero.
// R13 - De-emphasis enable bit switches the de-emphasis filter in.
// R14 - De-emphasis rate 00 44.1k, 01 48k, 10 32k, 11 reserved.
// R15 - Format field: right-justified 24/20/18/16, I2S, left-justified at reset.
// R16 - Rolloff bit picks sharp when clear, slow when set.
// R17 - Invert bit flips the phase of both outputs.
// R18 - Polarity bit: flags high on silence when clear, low when set.
// R19 - Common flag select puts combined flag on one pin, other unassigned.
// R20 - Latch low, sixteen shift clocks, latch rising edge writes the register.
// R21 - Silence is flagged after 1024 consecutive zero samples, per channel.
// R22 - Bits sampled on shift clock rise, MSB first; unknown indices ignored.
// R23 - Combined flag is set only while both channels are silent.
module stereo_dac_mode_control
   import stereo_dac_pkg::*;
(
   input  wire logic          clk_sys,
   input  wire logic          reset,
   input  wire logic          clkEn,
   input  wire logic          control_serial_data,
   input  wire logic          control_shift_clock,
   input  wire logic          control_latch_line,
   input  wire logic          sampleTick,
   input  wire logic          leftSampleZero,
   input  wire logic          rightSampleZero,
   output logic         [7:0] left_attenuation_level,
   output logic         [7:0] right_attenuation_level,
   output logic               leftChannelSilenced,
   output logic               rightChannelSilenced,
   output logic               oversampleHigh,
   output logic               left_channel_disable,
   output logic               right_channel_disable,
   output logic               deemphasis_enable,
   output deemph_rate_e       deemphasis_rate_select,
   output audio_format_e      audio_format_select,
   output logic               filter_rolloff_select,
   output logic               output_invert,
   output logic               left_silence_flag_pin,
   output logic               right_silence_flag_pin
);
   // ------------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------------
   logic [2:0] syncA_reg;
   logic [2:0] syncB_reg;
   logic       shiftPrev_reg;
   logic       latchPrev_reg;

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         syncA_reg     <= 3'h7;
         syncB_reg     <= 3'h7;
         shiftPrev_reg <= 1'b1;
         latchPrev_reg <= 1'b1;
      end else if (clkEn) begin
         syncA_reg     <= {control_latch_line, control_shift_clock, control_serial_data};
         syncB_reg     <= syncA_reg;
         shiftPrev_reg <= syncB_reg[1];
         latchPrev_reg <= syncB_reg[2];
      end
   end

   wire dataSync  = syncB_reg[0];
   wire shiftSync = syncB_reg[1];
   wire latchSync = syncB_reg[2];
   wire shiftRise = shiftSync && !shiftPrev_reg && !latchSync; // see R22
   wire latchRise = latchSync && !latchPrev_reg; // see R20
   wire latchFall = !latchSync && latchPrev_reg;

   // ------------------------------------------------------------------
   // Serial word receiver
   // ------------------------------------------------------------------
   logic [15:0] word_reg;
   logic [4:0]  bitCnt_reg;

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         word_reg   <= 16'h0000;
         bitCnt_reg <= 5'h00;
      end else if (clkEn) begin
         if (latchFall)
            bitCnt_reg <= 5'h00;
         else if (shiftRise) begin
            word_reg   <= {word_reg[14:0], dataSync}; // see R22
            if (bitCnt_reg != 5'h1F)
               bitCnt_reg <= 5'(bitCnt_reg + 5'h01);
         end
      end
   end

   wire [6:0] wordIndex = word_reg[`WORD_IDX_HI:`WORD_IDX_LO]; // see R1
   wire [7:0] wordData  = word_reg[7:0];
   wire       wordOk    = latchRise && (bitCnt_reg == 5'(`WORD_BITS)) &&
                          !word_reg[`WORD_ZERO_BIT]; // see R1 see R20
   wire       wrLeft    = wordOk && (wordIndex == `IDX_LEFT_ATTEN);
   wire       wrRight   = wordOk && (wordIndex == `IDX_RIGHT_ATTEN);
   wire       wrMute    = wordOk && (wordIndex == `IDX_MUTE_OVER);
   wire       wrChan    = wordOk && (wordIndex == `IDX_CHAN_DEEMPH);
   wire       wrFormat  = wordOk && (wordIndex == `IDX_FORMAT_FILTER);
   wire       wrOutput  = wordOk && (wordIndex == `IDX_OUTPUT_FLAG);
   // Index 15h holds only test bits; the host keeps them zero, so it is dropped here

   // ------------------------------------------------------------------
   // Mode registers
   // ------------------------------------------------------------------
   logic [7:0]    leftAtten_reg;
   logic [7:0]    rightAtten_reg;
   logic [1:0]    softMute_reg;
   logic          oversample_reg;
   logic [1:0]    disable_reg;
   logic          deemphEn_reg;
   deemph_rate_e  deemphRate_reg;
   audio_format_e format_reg;
   logic          rolloff_reg;
   logic          invert_reg;
   logic          flagPolarity_reg;
   logic          commonFlag_reg;

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         leftAtten_reg    <= `ATTEN_RESET; // see R3
         rightAtten_reg   <= `ATTEN_RESET;
         softMute_reg     <= 2'h0;
         oversample_reg   <= 1'b0;
         disable_reg      <= 2'h0;
         deemphEn_reg     <= 1'b0;
         deemphRate_reg   <= DEEMPH_44K1;
         format_reg       <= audio_format_e'(`FORMAT_RESET);
         rolloff_reg      <= 1'b0;
         invert_reg       <= 1'b0;
         flagPolarity_reg <= 1'b0;
         commonFlag_reg   <= 1'b0;
      end else if (clkEn) begin
         if (wrLeft)
            leftAtten_reg <= wordData; // see R3
         if (wrRight)
            rightAtten_reg <= wordData;
         if (wrMute) begin
            softMute_reg   <= {wordData[`POS_MUTE_RIGHT], wordData[`POS_MUTE_LEFT]}; // see R7
            oversample_reg <= wordData[`POS_OVERSAMPLE]; // see R9 see R10
         end
         if (wrChan) begin
            disable_reg    <= {wordData[`POS_DIS_RIGHT], wordData[`POS_DIS_LEFT]}; // see R12
            deemphEn_reg   <= wordData[`POS_DEEMPH_EN]; // see R13
            deemphRate_reg <= deemph_rate_e'(wordData[`POS_DEEMPH_RATE_LO +: 2]); // see R14
         end
         if (wrFormat) begin
            format_reg  <= audio_format_e'(wordData[`POS_FORMAT_LO +: 3]); // see R15
            rolloff_reg <= wordData[`POS_ROLLOFF]; // see R16
         end
         if (wrOutput) begin
            invert_reg       <= wordData[`POS_INVERT]; // see R17
            flagPolarity_reg <= wordData[`POS_FLAG_POLARITY]; // see R18
            commonFlag_reg   <= wordData[`POS_COMMON_FLAG]; // see R19
         end
      end
   end

   // ------------------------------------------------------------------
   // Per-channel attenuators and silence detectors
   // ------------------------------------------------------------------
   logic [7:0] appliedLevel [2];
   logic [1:0] silent;
   wire  [7:0] programmed [2];
   wire  [1:0] sampleZero = {rightSampleZero, leftSampleZero};

   assign programmed[0] = leftAtten_reg;
   assign programmed[1] = rightAtten_reg;

   genvar ch;
   generate
      for (ch = 0; ch < 2; ch++) begin : g_chan
         channel_attenuator u_atten (
            .clk_sys         (clk_sys),
            .reset           (reset),
            .clkEn           (clkEn),
            .sampleTick      (sampleTick),
            .sampleZero      (sampleZero[ch]),
            .programmedLevel (programmed[ch]),
            .softMute        (softMute_reg[ch]),
            .appliedLevel    (appliedLevel[ch]),
            .silent          (silent[ch])
         );
      end
   endgenerate

   // ------------------------------------------------------------------
   // Output stage
   // ------------------------------------------------------------------
   wire leftMuted   = appliedLevel[0] <= `ATTEN_MUTE_MAX; // see R5
   wire rightMuted  = appliedLevel[1] <= `ATTEN_MUTE_MAX;
   wire bothSilent  = &silent; // see R23
   wire flagLeft    = commonFlag_reg ? 1'b0 : silent[0];
   wire flagRight   = commonFlag_reg ? bothSilent : silent[1]; // see R19
   logic [3:0] outs_reg;

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         outs_reg <= 4'h0;
      end else if (clkEn) begin
         // Level codes pass straight on; the gain law is 0.5 dB per code below 255
         outs_reg[0] <= leftMuted || disable_reg[0]; // see R4 see R12
         outs_reg[1] <= rightMuted || disable_reg[1];
         outs_reg[2] <= flagLeft ^ flagPolarity_reg; // see R18
         outs_reg[3] <= flagRight ^ flagPolarity_reg;
      end
   end

   logic [7:0] leftOut_reg;
   logic [7:0] rightOut_reg;

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         leftOut_reg  <= `ATTEN_RESET;
         rightOut_reg <= `ATTEN_RESET;
      end else if (clkEn) begin
         leftOut_reg  <= appliedLevel[0]; // see R4
         rightOut_reg <= appliedLevel[1];
      end
   end

   assign left_attenuation_level  = leftOut_reg;
   assign right_attenuation_level = rightOut_reg;
   assign leftChannelSilenced     = outs_reg[0];
   assign rightChannelSilenced    = outs_reg[1];
   assign left_silence_flag_pin   = outs_reg[2];
   assign right_silence_flag_pin  = outs_reg[3];
   assign oversampleHigh          = oversample_reg;
   assign left_channel_disable    = disable_reg[0];
   assign right_channel_disable   = disable_reg[1];
   assign deemphasis_enable       = deemphEn_reg;
   assign deemphasis_rate_select  = deemphRate_reg;
   assign audio_format_select     = format_reg;
   assign filter_rolloff_select   = rolloff_reg;
   assign output_invert           = invert_reg;

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   a_bad_index_ignored: assert property (@(posedge clk_sys) disable iff (reset) // see R22
      (clkEn && latchRise && (wordIndex < `IDX_LEFT_ATTEN || wordIndex > `IDX_OUTPUT_FLAG))
      |=> $stable(leftAtten_reg) && $stable(format_reg) && $stable(invert_reg))
      else $error("write to unimplemented index changed a register");
   a_left_write: assert property (@(posedge clk_sys) disable iff (reset) // see R3
      (clkEn && wrLeft) |=> leftAtten_reg == $past(wordData))
      else $error("left attenuation not written");
   a_short_word: assert property (@(posedge clk_sys) disable iff (reset) // see R20
      (clkEn && latchRise && bitCnt_reg != 5'h10) |=> $stable(leftAtten_reg) && $stable(rightAtten_reg))
      else $error("short word wrote a register");
   a_msb_zero: assert property (@(posedge clk_sys) disable iff (reset) // see R1
      (clkEn && latchRise && word_reg[15]) |=> $stable(softMute_reg) && $stable(disable_reg))
      else $error("word with bit 15 set was accepted");
   a_mute_pin: assert property (@(posedge clk_sys) disable iff (reset) // see R12
      (clkEn && disable_reg[0]) |=> leftChannelSilenced)
      else $error("disabled left channel not held at zero");
   a_flag_pol: assert property (@(posedge clk_sys) disable iff (reset) // see R18
      (clkEn && !commonFlag_reg && silent[0]) |=> left_silence_flag_pin == !$past(flagPolarity_reg))
      else $error("left flag polarity wrong");
   a_common_flag: assert property (@(posedge clk_sys) disable iff (reset) // see R23
      (clkEn && commonFlag_reg && silent != 2'h3) |=> right_silence_flag_pin == $past(flagPolarity_reg))
      else $error("combined flag set without both channels silent");
   a_format_write: assert property (@(posedge clk_sys) disable iff (reset) // see R15 see R16
      (clkEn && wrFormat) |=> rolloff_reg == $past(wordData[5]) && output_invert == $past(invert_reg))
      else $error("format register write wrong");
endmodule // stereo_dac_mode_control
`default_nettype wire

// File: rtl/stereo_dac_pkg.sv
// Types shared by the DAC mode control bank
package stereo_dac_pkg;
   typedef enum logic [1:0] {DEEMPH_44K1, DEEMPH_48K, DEEMPH_32K, DEEMPH_RSVD} deemph_rate_e;
   typedef enum logic [2:0] {
      FMT_RJ24, FMT_RJ20, FMT_RJ18, FMT_RJ16, FMT_I2S, FMT_LJ, FMT_RSVD6, FMT_RSVD7
   } audio_format_e;
endpackage

// File: verif/serial_host.sv
// Host controller model that drives the three-wire serial control port
`timescale 1ns/1ps
`default_nettype none
module serial_host (
   output logic serialData,
   output logic shiftClock,
   output logic latchLine
);
   // ---------------------------------------------------------------
   // Word transmission, 400 ns shift period, clock idle low
   // ---------------------------------------------------------------
   initial begin
      serialData = 1'b0;
      shiftClock = 1'b0;
      latchLine  = 1'b1;
   end

   task automatic send_word(input logic [15:0] w, input int nbits);
      latchLine = 1'b0;
      #100;
      for (int i = 15; i > 15 - nbits; i--) begin
         serialData = w[i];
         #200 shiftClock = 1'b1;
         #200 shiftClock = 1'b0;
      end
      #100 latchLine = 1'b1;
      // Released data line shows the inverse so a stale bit cannot pass
      serialData = ~serialData;
      #400;
   endtask
endmodule // serial_host
`default_nettype wire

// File: verif/stereo_dac_mode_control_test.sv
// Self-checking bench of the DAC mode control bank
`timescale 1ns/1ps
`default_nettype none
module stereo_dac_mode_control_test
   import stereo_dac_pkg::*;
;
   logic clk_sys, reset, sampleTick, leftSampleZero, rightSampleZero;
   logic control_serial_data, control_shift_clock, control_latch_line;
   logic [7:0] left_attenuation_level, right_attenuation_level;
   logic leftChannelSilenced, rightChannelSilenced, oversampleHigh;
   logic left_channel_disable, right_channel_disable, deemphasis_enable;
   deemph_rate_e deemphasis_rate_select;
   audio_format_e audio_format_select;
   logic filter_rolloff_select, output_invert;
   logic left_silence_flag_pin, right_silence_flag_pin;
   int errors, nChecks, zeroTicks, zeroMode;
   logic [2:0] tickDiv, fmt;
   logic [1:0] rate;
   logic [7:0] r;

   stereo_dac_mode_control uut (.clk_sys, .reset, .clkEn(1'b1), .control_serial_data,
      .control_shift_clock, .control_latch_line, .sampleTick, .leftSampleZero,
      .rightSampleZero, .left_attenuation_level, .right_attenuation_level,
      .leftChannelSilenced, .rightChannelSilenced, .oversampleHigh, .left_channel_disable,
      .right_channel_disable, .deemphasis_enable, .deemphasis_rate_select,
      .audio_format_select, .filter_rolloff_select, .output_invert,
      .left_silence_flag_pin, .right_silence_flag_pin);
   serial_host host (.serialData(control_serial_data), .shiftClock(control_shift_clock),
      .latchLine(control_latch_line));

   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end

   // One sample tick every eight clocks, zero flags drawn per tick
   always @(negedge clk_sys) begin
      tickDiv <= tickDiv + 3'h1;
      sampleTick <= (tickDiv == 3'h0);
      if (tickDiv == 3'h0) begin
         leftSampleZero <= (zeroMode == 0) ? 1'($urandom) : (zeroMode >= 2);
         rightSampleZero <= (zeroMode == 0) ? 1'($urandom) : (zeroMode == 2);
         if (zeroMode == 2)
            zeroTicks <= zeroTicks + 1;
      end
   end

   function automatic logic flagLevel(logic silent, logic pol);
      return silent ^ pol;
   endfunction

   function automatic logic [7:0] stepSize(logic [7:0] a, logic [7:0] b);
      return (a > b) ? a - b : b - a;
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      nChecks++;
      if (seen !== exp) begin
         errors++;
         $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [6:0] idx, input logic [7:0] d);
      host.send_word({1'b0, idx, d}, 16);
      repeat (2) @(negedge clk_sys);
   endtask

   task automatic check_cfg();
      check(oversampleHigh, r[0]);
      check(deemphasis_enable, r[1]);
      check({right_channel_disable, left_channel_disable}, r[3:2]);
      check(leftChannelSilenced, r[2]);
      check(rightChannelSilenced, r[3]);
      check(deemphasis_rate_select, rate);
      check(audio_format_select, fmt);
      check(filter_rolloff_select, r[4]);
      check(output_invert, r[5]);
   endtask

   task automatic ramp(input logic [7:0] goal, input int limit);
      logic [7:0] prev;
      int k;
      prev = left_attenuation_level;
      k = 0;
      while (k < limit && left_attenuation_level !== goal
             && !(goal == 8'h80 && leftChannelSilenced === 1'b1)) begin
         @(negedge clk_sys);
         k++;
         if (left_attenuation_level !== prev && prev > 8'h80 && left_attenuation_level > 8'h80)
            check(stepSize(prev, left_attenuation_level), 1);
         prev = left_attenuation_level;
      end
      check(k < limit, 1);
   endtask

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", nChecks, errors);
      if (errors == 0 && nChecks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   initial begin
      repeat (60000) @(posedge clk_sys);
      errors++;
      $display("watchdog expired at %0t", $time);
      report_and_stop();
   end

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   initial begin
      reset = 1'b1;
      sampleTick = 1'b0;
      leftSampleZero = 1'b0;
      rightSampleZero = 1'b0;
      tickDiv = 3'h0;
      zeroMode = 1;
      zeroTicks = 0;
      errors = 0;
      nChecks = 0;
      void'($urandom(17548));
      repeat (3) @(negedge clk_sys);
      reset = 1'b0;
      repeat (2) @(negedge clk_sys);
      r = 8'h00;
      rate = 2'h0;
      fmt = 3'h5;
      check({left_attenuation_level, right_attenuation_level}, 16'hFFFF);
      check_cfg();
      check({left_silence_flag_pin, right_silence_flag_pin}, 0);
      $display("test reset values done");
      zeroMode = 0;
      for (int i = 0; i < 6; i++) begin
         rate = 2'(i % 3);
         fmt = 3'(i);
         r = 8'($urandom);
         wr(7'h12, {1'b0, r[0], 6'h00});
         wr(7'h13, {1'b0, rate, r[1], 2'b00, r[3:2]});
         wr(7'h14, {2'b00, r[4], 2'b00, fmt});
         wr(7'h16, {7'h00, r[5]});
         check_cfg();
      end
      $display("test configuration fields done");
      host.send_word({1'b1, 7'h13, 8'hFF}, 16);
      host.send_word({1'b0, 7'h15, 8'h00}, 16);
      host.send_word({1'b0, 7'h17, 8'hFF}, 16);
      host.send_word({1'b0, 7'h03, 8'hFF}, 16);
      host.send_word({1'b0, 7'h14, 8'hFF}, 15);
      repeat (4) @(negedge clk_sys);
      check_cfg();
      $display("test refused words done");
      wr(7'h13, 8'h00);
      wr(7'h16, 8'h00);
      wr(7'h10, 8'hFC);
      ramp(8'hFC, 400);
      check(right_attenuation_level, 8'hFF);
      wr(7'h12, 8'h01);
      ramp(8'h80, 9000);
      check(left_attenuation_level <= 8'h80, 1);
      check(right_attenuation_level, 8'hFF);
      wr(7'h12, 8'h00);
      ramp(8'hFC, 9000);
      check(left_attenuation_level, 8'hFC);
      $display("test attenuation ramps done");
      zeroMode = 1;
      repeat (20) @(negedge clk_sys);
      zeroMode = 2;
      zeroTicks = 0;
      while (zeroTicks < 1023)
         @(negedge clk_sys);
      repeat (4) @(negedge clk_sys);
      check({left_silence_flag_pin, right_silence_flag_pin}, 0);
      while (zeroTicks < 1025)
         @(negedge clk_sys);
      repeat (4) @(negedge clk_sys);
      check({left_silence_flag_pin, right_silence_flag_pin}, 2'b11);
      wr(7'h16, 8'h02);
      check(left_silence_flag_pin, flagLevel(1'b1, 1'b1));
      wr(7'h16, 8'h06);
      check(left_silence_flag_pin, flagLevel(1'b0, 1'b1));
      check(right_silence_flag_pin, flagLevel(1'b1, 1'b1));
      zeroMode = 3;
      repeat (16) @(negedge clk_sys);
      check(right_silence_flag_pin, flagLevel(1'b0, 1'b1));
      wr(7'h16, 8'h00);
      check(left_silence_flag_pin, flagLevel(1'b1, 1'b0));
      check(right_silence_flag_pin, flagLevel(1'b0, 1'b0));
      $display("test silence flags done");
      report_and_stop();
   end
endmodule // stereo_dac_mode_control_test
`default_nettype wire
